// File: core/itfm_mapper.sv
/*
 * Input terminal function mapper: synchronises, filters and inverts
 * seven logic terminals, then decodes them onto drive functions.
 * Assumes option, polarity and response settings are static-ish
 * levels from the drive's parameter store on the same clock.
 */
`timescale 1ns/1ps

module itfm_mapper (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         reset_n,
	// Terminal pins
	input  wire logic [itfm_pkg::NUM_TERM-1:0] term_pin,
	// Per-terminal settings
	input  wire logic [itfm_pkg::OPT_W-1:0]    term_option   [itfm_pkg::NUM_TERM],
	input  wire logic [itfm_pkg::NUM_TERM-1:0] term_polarity,
	input  wire logic [itfm_pkg::RESP_W-1:0]   term_resp     [itfm_pkg::NUM_TERM],
	// Filtered logical terminal states
	output logic      [itfm_pkg::NUM_TERM-1:0] term_active,
	// Decoded drive functions
	output itfm_pkg::itfm_func_t               func
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// Filters stay bypassed until the synchroniser holds real pin samples,
	// so a contact already closed at release acts without its filter delay
	logic [2:0] load_pipe;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			load_pipe <= 3'h0;
		end else begin
			load_pipe <= {load_pipe[1:0], 1'b1};
		end
	end

	// ****************************************
	// Pin synchroniser
	// ****************************************
	logic [itfm_pkg::NUM_TERM-1:0] pin_meta;
	logic [itfm_pkg::NUM_TERM-1:0] pin_sync;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 7'h00;
			pin_sync <= 7'h00;
		end else begin
			pin_meta <= term_pin;
			pin_sync <= pin_meta;
		end
	end

	// ****************************************
	// Shared 2 ms step tick
	// ****************************************
	logic [itfm_pkg::STEP_W-1:0] step_cnt;
	logic                        step_tick;

	assign step_tick = (step_cnt == itfm_pkg::STEP_W'(itfm_pkg::STEP_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_cnt <= '0;
		end else if (step_tick) begin
			step_cnt <= '0;
		end else begin
			step_cnt <= step_cnt + 1'b1;
		end
	end

	// ****************************************
	// Per-terminal polarity and filter
	// ****************************************
	// Fault reset may only be normally open
	function automatic logic eff_inverted(input logic [itfm_pkg::OPT_W-1:0] opt,
	                                      input logic pol);
		eff_inverted = (pol == itfm_pkg::POL_NC) &&
		               (opt != itfm_pkg::OPT_FAULT_RS);
	endfunction

	genvar g;
	generate
		for (g = 0; g < itfm_pkg::NUM_TERM; g++) begin : g_term
			logic                        logical;
			logic                        held;
			logic [itfm_pkg::RESP_W-1:0] limit;
			logic [itfm_pkg::RESP_W-1:0] steps;

			assign logical = pin_sync[g] ^ eff_inverted(term_option[g], term_polarity[g]);
			// Settings beyond range clamp to the longest response
			assign limit = (term_resp[g] > itfm_pkg::RESP_W'(itfm_pkg::RESP_MAX)) ?
			               itfm_pkg::RESP_W'(itfm_pkg::RESP_MAX) : term_resp[g];

			// A change must persist through limit shared step ticks, so the first step may be partial; a bounce restarts the wait
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					held  <= 1'b0;
					steps <= '0;
				end else if (!load_pipe[2] || logical == held) begin
					held  <= logical;
					steps <= '0;
				end else if (limit == '0) begin
					held  <= logical;
					steps <= '0;
				end else if (step_tick) begin
					if (steps + 1'b1 >= limit) begin
						held  <= logical;
						steps <= '0;
					end else begin
						steps <= steps + 1'b1;
					end
				end
			end

			assign term_active[g] = held;
		end
	endgenerate

	// ****************************************
	// Function decode
	// ****************************************
	// OR of every active terminal holding the given option
	function automatic logic any_with(input logic [itfm_pkg::NUM_TERM-1:0] act,
	                                  input logic [itfm_pkg::OPT_W-1:0] opts [itfm_pkg::NUM_TERM],
	                                  input logic [itfm_pkg::OPT_W-1:0] code);
		any_with = 1'b0;
		for (int i = 0; i < itfm_pkg::NUM_TERM; i++) begin
			any_with = any_with | (act[i] && opts[i] == code);
		end
	endfunction

	itfm_pkg::itfm_func_t next_func;
	logic                 fwd;
	logic                 rev;

	always_comb begin
		fwd = any_with(term_active, term_option, itfm_pkg::OPT_FWD_RUN);
		rev = any_with(term_active, term_option, itfm_pkg::OPT_REV_RUN);
		next_func = '0;
		// Conflicting directions stop rather than guess
		next_func.run     = fwd ^ rev;
		next_func.reverse = rev && !fwd;
		next_func.jog_run = any_with(term_active, term_option, itfm_pkg::OPT_JOG);
		next_func.speed_sel = {any_with(term_active, term_option, itfm_pkg::OPT_SPEED3),
		                       any_with(term_active, term_option, itfm_pkg::OPT_SPEED2),
		                       any_with(term_active, term_option, itfm_pkg::OPT_SPEED1),
		                       any_with(term_active, term_option, itfm_pkg::OPT_SPEED0)};
		next_func.dc_brake_request =
			any_with(term_active, term_option, itfm_pkg::OPT_DC_BRAKE);
		next_func.motor2_select =
			any_with(term_active, term_option, itfm_pkg::OPT_MOTOR2);
		next_func.second_ramp_select =
			any_with(term_active, term_option, itfm_pkg::OPT_RAMP2);
		next_func.coast_stop =
			any_with(term_active, term_option, itfm_pkg::OPT_COAST);
		next_func.fault_reset_input =
			any_with(term_active, term_option, itfm_pkg::OPT_FAULT_RS);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			func <= '0;
		end else begin
			func <= next_func;
		end
	end

endmodule // itfm_mapper

// File: core/itfm_pkg.sv
/*
 * Package for the input terminal function mapper: option codes,
 * polarity codes, filter timing and the decoded function bundle.
 * Assumes a 50 MHz control clock.
 */
package itfm_pkg;

	// ****************************************
	// Terminal geometry
	// ****************************************
	localparam int          NUM_TERM     = 7;
	localparam int          OPT_W        = 7;
	localparam int          RESP_W       = 8;

	// ****************************************
	// Option codes
	// ****************************************
	localparam logic [6:0]  OPT_FWD_RUN  = 7'h00;
	localparam logic [6:0]  OPT_REV_RUN  = 7'h01;
	localparam logic [6:0]  OPT_SPEED0   = 7'h02;
	localparam logic [6:0]  OPT_SPEED1   = 7'h03;
	localparam logic [6:0]  OPT_SPEED2   = 7'h04;
	localparam logic [6:0]  OPT_SPEED3   = 7'h05;
	localparam logic [6:0]  OPT_JOG      = 7'h06;
	localparam logic [6:0]  OPT_DC_BRAKE = 7'h07;
	localparam logic [6:0]  OPT_MOTOR2   = 7'h08;
	localparam logic [6:0]  OPT_RAMP2    = 7'h09;
	localparam logic [6:0]  OPT_COAST    = 7'h0B;
	localparam logic [6:0]  OPT_FAULT_RS = 7'h12;

	// ****************************************
	// Polarity codes
	// ****************************************
	localparam logic        POL_NO       = 1'h0;
	localparam logic        POL_NC       = 1'h1;

	// ****************************************
	// Filter timing
	// ****************************************
	localparam int          CLK_HZ       = 50000000;
	localparam int          RESP_STEP_US = 2000;
	localparam int          RESP_MAX     = 200;
	localparam int          STEP_CYCLES  = (CLK_HZ / 1000000) * RESP_STEP_US;
	localparam int          STEP_W       = $clog2(STEP_CYCLES);

	// ****************************************
	// Decoded function bundle
	// ****************************************
	typedef struct packed {
		logic       run;
		logic       reverse;
		logic       jog_run;
		logic [3:0] speed_sel;
		logic       dc_brake_request;
		logic       motor2_select;
		logic       second_ramp_select;
		logic       coast_stop;
		logic       fault_reset_input;
	} itfm_func_t;

endpackage

// File: test/itfm_mapper_checker.sv
/* Port checker for the terminal mapper.
   Assumes one clock and settings held while pins settle. */
`timescale 1ns/1ps
module itfm_mapper_checker (
	// Clock, reset and inputs
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire logic [6:0]           term_pin,
	input wire logic [6:0]           term_option [7],
	input wire logic [6:0]           term_polarity,
	input wire logic [7:0]           term_resp [7],
	// Outputs
	input wire logic [6:0]           term_active,
	input wire itfm_pkg::itfm_func_t func
);
	logic [18:0] h;
	logic [6:0]  lv;
	logic        zr;
	logic [2:0]  rc;
	always_comb begin
		h = '0;
		zr = 1'b1;
		for (int i = 0; i < 7; i++) begin
			lv[i] = term_pin[i] ^ (term_polarity[i] && term_option[i] != 7'h12);
			zr = zr && term_resp[i] == 8'h00;
			if (term_active[i] && term_option[i] < 7'h13) h[term_option[i]] = 1'b1;
		end
	end
	// Settle time after reset, the filter bypass load lands inside it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) rc <= 3'h0;
		else if (rc != 3'h7) rc <= rc + 3'h1;
	end
	// ********
	// Assertions
	// ********
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	run_dir_a: assert property (func.run == $past(h[0] ^ h[1])) else $error("run");
	rev_dir_a: assert property (func.reverse == $past(h[1] & ~h[0])) else $error("rev");
	speed_idx_a: assert property (func.speed_sel == $past(h[5:2])) else $error("speed");
	jog_run_a: assert property (func.jog_run == $past(h[6])) else $error("jog");
	dc_brake_a: assert property (func.dc_brake_request == $past(h[7])) else $error("brake");
	motor_two_a: assert property (func.motor2_select == $past(h[8])) else $error("motor2");
	ramp_two_a: assert property (func.second_ramp_select == $past(h[9])) else $error("ramp");
	coast_stop_a: assert property (func.coast_stop == $past(h[11])) else $error("coast");
	fault_rs_a: assert property (func.fault_reset_input == $past(h[18])) else $error("rs");
	term_level_a: assert property ((zr && rc == 3'h7 && $stable(lv)) [*4] |-> term_active == lv)
		else $error("level");
endmodule // itfm_mapper_checker
bind itfm_mapper itfm_mapper_checker u_chk (.clk(clk), .reset_n(reset_n), .term_pin(term_pin),
	.term_option(term_option), .term_polarity(term_polarity), .term_resp(term_resp),
	.term_active(term_active), .func(func));

// File: test/itfm_contacts.sv
/* Contact model for the terminals.
   Assumes the bench sets the wanted states. */
`timescale 1ns/1ps
module itfm_contacts (
	// Clock and wanted states
	input  wire logic       clk,
	input  wire logic [6:0] want,
	// Terminal pins
	output logic      [6:0] pins
);
	initial pins = 7'h00;
	// Contacts move off the sampling edge
	always @(negedge clk) pins <= want;
endmodule // itfm_contacts

// File: test/itfm_mapper_tb.sv
/* Testbench for the terminal mapper.
   Assumes a 50 MHz clock and contacts moved on falling edges. */
`timescale 1ns/1ps
module itfm_mapper_tb;
	logic                 clk;
	logic                 reset_n;
	logic [6:0]           want;
	logic [6:0]           pins;
	logic [6:0]           pol;
	logic [6:0]           act;
	logic [6:0]           opt [7];
	logic [7:0]           resp [7];
	itfm_pkg::itfm_func_t func;
	int                   fails;
	int                   n_checks;
	int                   cyc;
	logic [6:0]           codes [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
		7'h06, 7'h07, 7'h08, 7'h09, 7'h0B, 7'h12};
	itfm_contacts u_sw (.clk(clk), .want(want), .pins(pins));
	itfm_mapper u_dut (.clk(clk), .reset_n(reset_n), .term_pin(pins), .term_option(opt),
		.term_polarity(pol), .term_resp(resp), .term_active(act), .func(func));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// ********
	// Tasks
	// ********
	function automatic itfm_pkg::itfm_func_t efn(input logic [6:0] lv);
		logic [18:0]          h;
		itfm_pkg::itfm_func_t f;
		h = '0;
		for (int i = 0; i < 7; i++) if (lv[i] && opt[i] < 7'h13) h[opt[i]] = 1'b1;
		f = '0;
		f.run = h[0] ^ h[1];
		f.reverse = h[1] & ~h[0];
		f.jog_run = h[6];
		f.speed_sel = h[5:2];
		f.dc_brake_request = h[7];
		f.motor2_select = h[8];
		f.second_ramp_select = h[9];
		f.coast_stop = h[11];
		f.fault_reset_input = h[18];
		return f;
	endfunction
	task automatic cmp_act(input logic [6:0] e);
		n_checks++;
		if (act !== e) begin
			fails++;
			$display("FAIL %0t active %h exp %h", $time, act, e);
		end
	endtask
	task automatic cmp_func(input itfm_pkg::itfm_func_t e);
		n_checks++;
		if (func !== e) begin
			fails++;
			$display("FAIL %0t func %h exp %h", $time, func, e);
		end
	endtask
	task automatic apply(input logic [6:0] p);
		logic [6:0] lv;
		want <= p;
		repeat (8) @(negedge clk);
		for (int i = 0; i < 7; i++) lv[i] = p[i] ^ (pol[i] && opt[i] != 7'h12);
		cmp_act(lv);
		cmp_func(efn(lv));
	endtask
	task automatic complete_run;
		if (fails == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			complete_run();
		end
	end
	// ********
	// Tests
	// ********
	initial begin
		reset_n = 1'b0;
		want = 7'h00;
		pol = 7'h00;
		for (int i = 0; i < 7; i++) begin
			opt[i] = 7'h7F;
			resp[i] = 8'h00;
		end
		repeat (16) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		for (int j = 0; j < 12; j++) begin
			opt[j % 7] = codes[j];
			apply(7'h01 << (j % 7));
			apply(7'h00);
			opt[j % 7] = 7'h7F;
		end
		opt[0] = 7'h00;
		opt[1] = 7'h01;
		apply(7'h03);
		apply(7'h02);
		opt[2] = 7'h02;
		opt[5] = 7'h02;
		apply(7'h20);
		apply(7'h24);
		opt[3] = 7'h0B;
		pol = 7'h08;
		apply(7'h00);
		apply(7'h08);
		opt[4] = 7'h12;
		pol = 7'h18;
		apply(7'h10);
		pol = 7'h00;
		apply(7'h01);
		// Longest filter, yet reset must load the pins at once
		for (int i = 0; i < 7; i++) resp[i] = 8'hC8;
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		repeat (6) @(negedge clk);
		cmp_act(7'h01);
		cmp_func(efn(7'h01));
		complete_run();
	end
endmodule // itfm_mapper_tb
